// [core/pefm_pkg.sv]
// package: constants and carrier types for the event flag and mask block
package pefm_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] PEFM_ADDR_FLAGS_A = 8'h01;
   localparam logic [7:0] PEFM_ADDR_FLAGS_B = 8'h02;
   localparam logic [7:0] PEFM_ADDR_MASK_A = 8'h03;
   localparam logic [7:0] PEFM_RST_FLAGS_A = 8'h00;
   localparam logic [7:0] PEFM_RST_FLAGS_B = 8'h00;
   localparam logic [7:0] PEFM_RST_MASK_A = 8'h00;
   localparam logic [7:0] PEFM_RDATA_NONE = 8'h00;
   localparam logic [1:0] PEFM_RSVD_ZERO = 2'h0;

   // ---------------------------------------------------------------
   // field layout (both flag registers and the mask use bits 5..0)
   // ---------------------------------------------------------------
   localparam int PEFM_FIELD_W = 6;
   localparam int PEFM_BIT_LOW_SUPPLY = 5;
   localparam int PEFM_BIT_ADAPTER = 4;
   localparam int PEFM_BIT_BUTTON = 3;
   localparam int PEFM_BIT_THERMAL = 2;
   localparam int PEFM_BIT_CC_DONE = 1;
   localparam int PEFM_BIT_NVM_DONE = 0;
   localparam int PEFM_SW_CNT = 3;
   localparam int PEFM_BIT_FAULT_LSB = 3;
   localparam int PEFM_BIT_LIMIT_LSB = 0;
   localparam logic [PEFM_FIELD_W-1:0] PEFM_FIELD_ZERO = 6'h00;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   // raw condition indications from the analog and nvm circuits
   typedef struct packed {
      logic low_supply;
      logic thermal;
      logic cc_done;
      logic nvm_done;
      logic [PEFM_SW_CNT-1:0] sw_fault;
      logic [PEFM_SW_CNT-1:0] sw_limit;
   } pefm_cond_t;

   localparam int PEFM_COND_W = $bits(pefm_cond_t);

   // one register access from the serial register port
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pefm_req_t;

endpackage

// [core/pefm_sync.sv]
// module: three-stage input synchroniser with agreement filter and edge pulses
`timescale 1ns/100ps

module pefm_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous inputs
   input wire logic [W-1:0] d,
   // filtered level and one-cycle change pulses
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] filt_reg;
   logic [W-1:0] filt_next;

   // a bit changes only once stages two and three agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         filt_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : filt_reg[i];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         filt_reg <= RST_VAL;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= filt_next;
      end
   end

   assign level = filt_reg;
   assign rise = filt_next & ~filt_reg;
   assign fall = ~filt_next & filt_reg;

endmodule

// [core/pefm_ctrl.sv]
// module: interrupt event flags, event mask and open-drain interrupt output
//
// How it works
// RULE1: flags A at 0x01, reset zero, top bits zero
// RULE2: flag A bit5 while supply too low
// RULE3: flag A bit4 on any adapter pin edge
// RULE4: flag A bit3 on any button edge
// RULE5: flag A bit2 on thermal warning rise
// RULE6: flag A bit1 when coin-cell comparators settle
// RULE7: flag A bit0 when nvm programming completes
// RULE8: live adapter and button levels kept separately
// RULE9: flags B at 0x02, reset zero, top bits zero
// RULE10: flag B bit5 on switch3 fault, disable it
// RULE11: flag B bit4 on switch2 fault, disable it
// RULE12: flag B bit3 on switch1 fault, disable it
// RULE13: flag B bits2..0 show switch current limiting
// RULE14: mask A at 0x03, reset zero, bits 5..0
// RULE15: mask 0 drives interrupt, 1 blocks it
// RULE16: mask never stops recording of events
// RULE17: level bits read 1 when pin low
// RULE18: interrupt low while unmasked flag remains set
// RULE19: reading a flag register clears its flags
`timescale 1ns/100ps

module pefm_ctrl
   import pefm_pkg::*;
#(
   parameter int SW_CNT = PEFM_SW_CNT
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // serial register port, same clock domain
   input wire pefm_req_t req,
   output logic [7:0] rdata,
   // external pins
   input wire logic adapter_detect_pin,
   input wire logic push_button_pin,
   // condition indications from analog and nvm circuits
   input wire pefm_cond_t cond,
   // open-drain interrupt pin, driven low when oe is low
   output logic irq_n_out,
   output logic irq_n_out_oe_n,
   // live pin levels for the status register
   output logic adapter_level_bit,
   output logic button_level_bit,
   // load switch temporary disable
   output logic [SW_CNT-1:0] sw_disable
);

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_addr);
      addr_hit = (a == ref_addr);
   endfunction

   // reserved top bits always read back as zero
   function automatic logic [7:0] pack_reg(input logic [PEFM_FIELD_W-1:0] f);
      pack_reg = {PEFM_RSVD_ZERO, f};
   endfunction

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] pin_level;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;
   logic [PEFM_COND_W-1:0] cond_level;
   logic [PEFM_COND_W-1:0] cond_rise;
   pefm_cond_t lvl;
   pefm_cond_t up;
   logic [1:0] pin_raw;

   assign pin_raw = {adapter_detect_pin, push_button_pin};

   // pins idle high, so they reset high to avoid a false change edge
   pefm_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_pin_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(pin_raw),
      .level(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   pefm_sync #(
      .W(PEFM_COND_W),
      .RST_VAL('0)
   ) u_cond_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(cond),
      .level(cond_level),
      .rise(cond_rise),
      .fall()
   );

   assign lvl = pefm_cond_t'(cond_level);
   assign up = pefm_cond_t'(cond_rise);

   // ---------------------------------------------------------------
   // access strobes
   // ---------------------------------------------------------------
   logic rd_flags_a;
   logic rd_flags_b;
   logic wr_mask_a;
   logic rd_mask_a;
   logic rd_unmapped;

   always_comb begin
      rd_flags_a = 1'b0;
      rd_flags_b = 1'b0;
      rd_mask_a = 1'b0;
      wr_mask_a = 1'b0;
      if (addr_hit(req.addr, PEFM_ADDR_FLAGS_A)) begin
         rd_flags_a = req.rd;
      end else if (addr_hit(req.addr, PEFM_ADDR_FLAGS_B)) begin
         rd_flags_b = req.rd;
      end else if (addr_hit(req.addr, PEFM_ADDR_MASK_A)) begin
         rd_mask_a = req.rd;
         wr_mask_a = req.wr;
      end
   end

   // an unmapped read returns zero
   assign rd_unmapped = req.rd & ~(rd_flags_a | rd_flags_b | rd_mask_a);

   // ---------------------------------------------------------------
   // event sources
   // ---------------------------------------------------------------
   logic [PEFM_FIELD_W-1:0] set_a;
   logic [PEFM_FIELD_W-1:0] set_b;
   logic [SW_CNT-1:0] limit_active;
   logic adapter_change;
   logic button_change;

   // either edge of a pin counts as a change
   assign adapter_change = pin_rise[1] | pin_fall[1]; // [RULE3]
   assign button_change = pin_rise[0] | pin_fall[0]; // [RULE4]

   always_comb begin
      set_a = PEFM_FIELD_ZERO;
      set_a[PEFM_BIT_LOW_SUPPLY] = lvl.low_supply; // [RULE2]
      set_a[PEFM_BIT_ADAPTER] = adapter_change; // [RULE3]
      set_a[PEFM_BIT_BUTTON] = button_change; // [RULE4]
      set_a[PEFM_BIT_THERMAL] = up.thermal; // [RULE5]
      set_a[PEFM_BIT_CC_DONE] = up.cc_done; // [RULE6]
      set_a[PEFM_BIT_NVM_DONE] = up.nvm_done; // [RULE7]
   end

   // ---------------------------------------------------------------
   // per-switch fault and limit
   // ---------------------------------------------------------------
   logic [SW_CNT-1:0] fault_rise;
   logic [SW_CNT-1:0] fault_lvl;
   logic [SW_CNT-1:0] limit_lvl;

   assign fault_rise = up.sw_fault;
   assign fault_lvl = lvl.sw_fault;
   assign limit_lvl = lvl.sw_limit;

   for (genvar g = 0; g < SW_CNT; g++) begin : g_sw
      // a switch in fault is disabled, so it cannot report limiting
      assign limit_active[g] = limit_lvl[g] & ~fault_lvl[g]; // [RULE13]
      // the switch stays off while its fault condition persists
      assign sw_disable[g] = fault_lvl[g]; // [RULE10] [RULE11] [RULE12]
   end

   always_comb begin
      set_b = PEFM_FIELD_ZERO;
      set_b[PEFM_BIT_FAULT_LSB +: SW_CNT] = fault_rise; // [RULE10] [RULE11] [RULE12]
      set_b[PEFM_BIT_LIMIT_LSB +: SW_CNT] = limit_active; // [RULE13]
   end

   // ---------------------------------------------------------------
   // flag and mask registers
   // ---------------------------------------------------------------
   logic [PEFM_FIELD_W-1:0] flags_a_reg;
   logic [PEFM_FIELD_W-1:0] flags_a_next;
   logic [PEFM_FIELD_W-1:0] flags_b_reg;
   logic [PEFM_FIELD_W-1:0] flags_b_next;
   logic [PEFM_FIELD_W-1:0] mask_a_reg;
   logic [PEFM_FIELD_W-1:0] mask_a_next;

   // read clears, but an event in the same cycle wins over the clear
   always_comb begin
      flags_a_next = rd_flags_a ? PEFM_FIELD_ZERO : flags_a_reg; // [RULE19]
      flags_a_next = flags_a_next | set_a; // [RULE16]
      flags_b_next = rd_flags_b ? PEFM_FIELD_ZERO : flags_b_reg; // [RULE19]
      flags_b_next = flags_b_next | set_b;
      mask_a_next = mask_a_reg;
      if (wr_mask_a) begin
         mask_a_next = req.wdata[PEFM_FIELD_W-1:0]; // [RULE14]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flags_a_reg <= PEFM_RST_FLAGS_A[PEFM_FIELD_W-1:0]; // [RULE1]
         flags_b_reg <= PEFM_RST_FLAGS_B[PEFM_FIELD_W-1:0]; // [RULE9]
         mask_a_reg <= PEFM_RST_MASK_A[PEFM_FIELD_W-1:0]; // [RULE14]
      end else begin
         flags_a_reg <= flags_a_next;
         flags_b_reg <= flags_b_next;
         mask_a_reg <= mask_a_next;
      end
   end

   // ---------------------------------------------------------------
   // read data
   // ---------------------------------------------------------------
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // read data holds until the next read
   always_comb begin
      rdata_next = rdata_reg;
      if (rd_flags_a) begin
         rdata_next = pack_reg(flags_a_reg); // [RULE1]
      end else if (rd_flags_b) begin
         rdata_next = pack_reg(flags_b_reg); // [RULE9]
      end else if (rd_mask_a) begin
         rdata_next = pack_reg(mask_a_reg); // [RULE14]
      end else if (rd_unmapped) begin
         rdata_next = PEFM_RDATA_NONE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= PEFM_RDATA_NONE;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;

   // ---------------------------------------------------------------
   // status levels
   // ---------------------------------------------------------------
   logic adapter_lvl_reg;
   logic button_lvl_reg;
   logic adapter_lvl_next;
   logic button_lvl_next;

   // active level is a low pin, kept apart from the change flags
   always_comb begin
      adapter_lvl_next = ~pin_level[1]; // [RULE8] [RULE17]
      button_lvl_next = ~pin_level[0]; // [RULE8] [RULE17]
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         adapter_lvl_reg <= 1'b0;
         button_lvl_reg <= 1'b0;
      end else begin
         adapter_lvl_reg <= adapter_lvl_next;
         button_lvl_reg <= button_lvl_next;
      end
   end

   assign adapter_level_bit = adapter_lvl_reg;
   assign button_level_bit = button_lvl_reg;

   // ---------------------------------------------------------------
   // interrupt output
   // ---------------------------------------------------------------
   logic irq_act_reg;
   logic irq_act_next;

   // ---------------------------------------------------------------
   // pending interrupts
   // ---------------------------------------------------------------
   logic [PEFM_FIELD_W-1:0] pend_a;
   logic [PEFM_FIELD_W-1:0] pend_b;

   // flags B have no mask in this block and always reach the pin
   // a masked flag is still recorded, it only stays off the pin
   always_comb begin
      pend_a = flags_a_next & ~mask_a_next; // [RULE15] [RULE16]
      pend_b = flags_b_next;
      irq_act_next = (|pend_a) | (|pend_b); // [RULE18]
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_act_reg <= 1'b0;
      end else begin
         irq_act_reg <= irq_act_next;
      end
   end

   assign irq_n_out = 1'b0;
   assign irq_n_out_oe_n = ~irq_act_reg; // [RULE18]

endmodule

// [tb/pefm_ctrl_monitor.sv]
// checker: port-level assertions for the event flag and mask block
`timescale 1ns/100ps
module pefm_ctrl_monitor
   import pefm_pkg::*;
#(
   parameter int SW_CNT = PEFM_SW_CNT
) (
   // clock, reset, register port
   input wire logic clk,
   input wire logic rst_b,
   input wire pefm_req_t req,
   input wire logic [7:0] rdata,
   // pins and conditions
   input wire logic adapter_detect_pin,
   input wire logic push_button_pin,
   input wire pefm_cond_t cond,
   input wire logic irq_n_out,
   input wire logic irq_n_out_oe_n,
   input wire logic adapter_level_bit,
   input wire logic button_level_bit,
   input wire logic [SW_CNT-1:0] sw_disable
);
   logic [5:0] mask_reg;
   logic [5:0] mask_next;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   always_comb begin
      mask_next = mask_reg;
      if (req.wr && req.addr == PEFM_ADDR_MASK_A) begin
         mask_next = req.wdata[5:0];
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_reg <= 6'h00;
      end else begin
         mask_reg <= mask_next;
      end
   end
   rsvd_zero_a: assert property (rdata[7:6] == 2'h0)
      else $error("reserved bits set");
   unmapped_read_a: assert property (req.rd && (req.addr == 8'h00 || req.addr > 8'h03)
      |=> rdata == 8'h00) else $error("unmapped read not zero");
   mask_readback_a: assert property (req.rd && req.addr == PEFM_ADDR_MASK_A
      |=> rdata == {2'h0, $past(mask_reg)}) else $error("mask readback wrong");
   adapter_level_a: assert property ($stable(adapter_detect_pin)[*6]
      |-> adapter_level_bit == !adapter_detect_pin) else $error("adapter level wrong");
   button_level_a: assert property ($stable(push_button_pin)[*6]
      |-> button_level_bit == !push_button_pin) else $error("button level wrong");
   adapter_irq_a: assert property ($changed(adapter_detect_pin) && !mask_reg[4]
      |-> ##[1:6] !irq_n_out_oe_n) else $error("adapter change gave no interrupt");
   button_irq_a: assert property ($changed(push_button_pin) && !mask_reg[3]
      |-> ##[1:6] !irq_n_out_oe_n) else $error("button change gave no interrupt");
   irq_drive_a: assert property (irq_n_out == 1'b0)
      else $error("interrupt data not low");
   sw1_off_a: assert property ($rose(cond.sw_fault[0]) |-> ##[1:5] sw_disable[0])
      else $error("switch1 not disabled");
   sw2_off_a: assert property ($rose(cond.sw_fault[1]) |-> ##[1:5] sw_disable[1])
      else $error("switch2 not disabled");
   sw3_off_a: assert property ($rose(cond.sw_fault[2]) |-> ##[1:5] sw_disable[2])
      else $error("switch3 not disabled");
   read_hold_a: assert property (!$past(req.rd) |-> $stable(rdata))
      else $error("read data changed without read");
   cover property ($fell(irq_n_out_oe_n));
   cover property ($rose(irq_n_out_oe_n));
   cover property (req.wr && req.addr == PEFM_ADDR_MASK_A);
endmodule

// [tb/pefm_host_model.sv]
// partner: host that reaches the registers and watches the interrupt line
`timescale 1ns/100ps
module pefm_host_model
   import pefm_pkg::*;
(
   // clock and register port
   input wire logic clk,
   output pefm_req_t req,
   input wire logic [7:0] rdata,
   // interrupt pin
   input wire logic irq_n_out,
   input wire logic irq_n_out_oe_n,
   output logic irq_line
);
   // board pull-up holds the released line high
   assign irq_line = irq_n_out_oe_n ? 1'b1 : irq_n_out;
   initial begin
      req = '0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: v};
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~v};
   endtask
   // a read clears the flags of that register
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(negedge clk);
      req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk);
      req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hFF};
      v = rdata;
   endtask
endmodule

// [tb/pmic_event_flags_and_masks_bench.sv]
// testbench: register, event and interrupt scenarios for the flag block
`timescale 1ns/100ps
module pmic_event_flags_and_masks_bench;
   import pefm_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ad_pin = 1'b1;
   logic pb_pin = 1'b1;
   pefm_cond_t cond = '0;
   pefm_req_t req;
   logic [7:0] rdata;
   logic irq_n_out, irq_n_out_oe_n, irq_line, ad_lvl, pb_lvl;
   logic [2:0] sw_dis;
   logic [7:0] d;
   int bad_count = 0;
   int checked = 0;
   int cycles = 0;
   always #12.5 clk = ~clk;
   pefm_ctrl pefm_ctrl_inst (.clk(clk), .rst_b(rst_b), .req(req), .rdata(rdata),
      .adapter_detect_pin(ad_pin), .push_button_pin(pb_pin), .cond(cond),
      .irq_n_out(irq_n_out), .irq_n_out_oe_n(irq_n_out_oe_n), .adapter_level_bit(ad_lvl),
      .button_level_bit(pb_lvl), .sw_disable(sw_dis));
   pefm_host_model pefm_host_model_inst (.clk(clk), .req(req), .rdata(rdata),
      .irq_n_out(irq_n_out), .irq_n_out_oe_n(irq_n_out_oe_n), .irq_line(irq_line));
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      pefm_host_model_inst.rd_reg(a, d);
      chk(name, exp, d);
   endtask
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic src(input int b, input logic v);
      case (b)
         5: cond.low_supply = v;
         4: ad_pin = ~v;
         3: pb_pin = ~v;
         2: cond.thermal = v;
         1: cond.cc_done = v;
         default: cond.nvm_done = v;
      endcase
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         summarize();
      end
   end
   initial begin
      hold(10);
      rst_b = 1'b1;
      hold(6);
      rd(PEFM_ADDR_FLAGS_A, PEFM_RST_FLAGS_A, "flags_a");
      rd(PEFM_ADDR_FLAGS_B, PEFM_RST_FLAGS_B, "flags_b");
      rd(PEFM_ADDR_MASK_A, PEFM_RST_MASK_A, "mask");
      rd(8'h04, 8'h00, "unmapped");
      pefm_host_model_inst.wr_reg(PEFM_ADDR_FLAGS_A, 8'hFF);
      pefm_host_model_inst.wr_reg(PEFM_ADDR_MASK_A, 8'hFF);
      rd(PEFM_ADDR_FLAGS_A, 8'h00, "flags_a ro");
      rd(PEFM_ADDR_MASK_A, 8'h3F, "mask");
      for (int b = 5; b >= 0; b--) begin
         src(b, 1'b1);
         hold(8);
         chk("irq masked", 8'h01, {7'h00, irq_line});
         chk("levels", {6'h00, ~ad_pin, ~pb_pin}, {6'h00, ad_lvl, pb_lvl});
         rd(PEFM_ADDR_FLAGS_A, 8'h01 << b, "flag");
         src(b, 1'b0);
         hold(8);
         rd(PEFM_ADDR_FLAGS_A, (b >= 3) ? 8'h01 << b : 8'h00, "release");
         rd(PEFM_ADDR_FLAGS_A, 8'h00, "cleared");
      end
      pefm_host_model_inst.wr_reg(PEFM_ADDR_MASK_A, 8'hC0);
      rd(PEFM_ADDR_MASK_A, 8'h00, "mask top");
      src(4, 1'b1);
      src(3, 1'b1);
      hold(8);
      chk("irq low", 8'h00, {7'h00, irq_line});
      rd(PEFM_ADDR_FLAGS_A, 8'h18, "pins");
      chk("irq free", 8'h01, {7'h00, irq_line});
      src(4, 1'b0);
      src(3, 1'b0);
      hold(8);
      rd(PEFM_ADDR_FLAGS_A, 8'h18, "pins rise");
      for (int s = 0; s < 3; s++) begin
         cond.sw_fault[s] = 1'b1;
         cond.sw_limit[s] = 1'b1;
         hold(8);
         chk("disable", 8'h01 << s, {5'h00, sw_dis});
         chk("irq b", 8'h00, {7'h00, irq_line});
         rd(PEFM_ADDR_FLAGS_B, 8'h08 << s, "fault");
         cond.sw_fault[s] = 1'b0;
         hold(8);
         rd(PEFM_ADDR_FLAGS_B, 8'h01 << s, "limit");
         cond.sw_limit[s] = 1'b0;
         hold(8);
         rd(PEFM_ADDR_FLAGS_B, 8'h01 << s, "limit end");
         rd(PEFM_ADDR_FLAGS_B, 8'h00, "b clear");
      end
      summarize();
   end
endmodule
bind pefm_ctrl pefm_ctrl_monitor #(.SW_CNT(SW_CNT)) pefm_ctrl_monitor_inst (.clk(clk),
   .rst_b(rst_b), .req(req), .rdata(rdata), .adapter_detect_pin(adapter_detect_pin),
   .push_button_pin(push_button_pin), .cond(cond), .irq_n_out(irq_n_out),
   .irq_n_out_oe_n(irq_n_out_oe_n), .adapter_level_bit(adapter_level_bit),
   .button_level_bit(button_level_bit), .sw_disable(sw_disable));
